//--- core/enc_channel.sv
// One counting channel: pulse count, period timing, quadrature direction
`timescale 1ns/1ps
`include "enc_params.svh"
module enc_channel
   import enc_pkg::*;
(
   input logic clk,
   input logic sys_rst,
   enc_ch_if.chan bus
);
   enc_chan_state_t q;
   enc_chan_state_t d;
   logic firstRise;
   logic firstChg;
   logic secondChg;
   logic up;

   always_comb begin
      d = q;
      firstRise = bus.trackFirst & ~q.prevTracks[1];
      firstChg = bus.trackFirst ^ q.prevTracks[1];
      secondChg = bus.trackSecond ^ q.prevTracks[0];
      // A high with B low on an edge of A means forward motion
      up = bus.trackFirst ^ bus.trackSecond;
      // Tracked even while held, so enabling never fakes an edge
      d.prevTracks = {bus.trackFirst, bus.trackSecond};
      if (bus.clear) begin
         d.count = '0;
         d.period = '0;
         d.stamp = '0;
         d.stampValid = 1'b0;
         d.periodValid = 1'b0;
         d.dir = 1'b0;
      end else if (bus.countEn) begin
         if (firstRise) begin
            if (q.stampValid) begin
               d.period = bus.timeNow - q.stamp;
               d.periodValid = 1'b1;
            end
            d.stamp = bus.timeNow;
            d.stampValid = 1'b1;
         end
         unique case (bus.mode)
            ENC_MODE_EVENT, ENC_MODE_TIME: begin
               d.dir = 1'b0;
               if (firstRise) begin
                  d.count = q.count + `ENC_CNT_W'(1);
               end
            end
            ENC_MODE_QUAD: begin
               // Both tracks moving at once carries no direction
               if (firstChg && !secondChg) begin
                  d.dir = up;
                  d.count = up ? q.count + `ENC_CNT_W'(1) : q.count - `ENC_CNT_W'(1);
               end
            end
            default: d = q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.count = q.count;
   assign bus.period = q.period;
   assign bus.periodValid = q.periodValid;
   assign bus.dir = q.dir;

   property p_hold_inactive;
      @(posedge clk) disable iff (sys_rst)
      !bus.countEn && !bus.clear |=> $stable(q.count);
   endproperty
   a_hold_inactive: assert property (p_hold_inactive) else $error("count moved while held");

   property p_quad_both;
      @(posedge clk) disable iff (sys_rst)
      bus.countEn && !bus.clear && bus.mode == ENC_MODE_QUAD && firstChg && secondChg
      |=> $stable(q.count);
   endproperty
   a_quad_both: assert property (p_quad_both) else $error("double change was counted");

   property p_quad_step;
      @(posedge clk) disable iff (sys_rst)
      bus.countEn && !bus.clear && bus.mode == ENC_MODE_QUAD && firstChg && !secondChg
      |=> q.count == ($past(up) ? $past(q.count) + 1 : $past(q.count) - 1);
   endproperty
   a_quad_step: assert property (p_quad_step) else $error("quadrature step wrong");

   property p_single_track;
      @(posedge clk) disable iff (sys_rst)
      bus.countEn && !bus.clear && bus.mode != ENC_MODE_QUAD && !firstChg
      |=> $stable(q.count) && !q.dir;
   endproperty
   a_single_track: assert property (p_single_track) else $error("second track counted");

   property p_period;
      @(posedge clk) disable iff (sys_rst)
      bus.countEn && !bus.clear && firstRise && q.stampValid
      |=> q.period == $past(bus.timeNow) - $past(q.stamp) && q.periodValid;
   endproperty
   a_period: assert property (p_period) else $error("period not captured");

   c_quad_down: cover property (@(posedge clk) disable iff (sys_rst)
      bus.mode == ENC_MODE_QUAD ##1 $past(q.count) - 1 == q.count);
   c_period: cover property (@(posedge clk) disable iff (sys_rst) $rose(q.periodValid));
endmodule // enc_channel

//--- core/enc_counter.sv
// Four-channel incremental encoder counter with shared index gating
`timescale 1ns/1ps
`include "enc_params.svh"
module enc_counter
   import enc_pkg::*;
#(
   parameter int NUM_CH = `ENC_NUM_CH,
   parameter bit FIXED_LEVELS = 1'b1
) (
   input logic clk,
   input logic sys_rst,
   input logic signed [2*NUM_CH-1:0][`ENC_LEVEL_W-1:0] trackLevel,
   input logic signed [`ENC_LEVEL_W-1:0] indexLevel,
   input logic signed [`ENC_LEVEL_W-1:0] thresholdMv,
   input logic [`ENC_LEVEL_W-1:0] hysteresis_width,
   input enc_mode_t [NUM_CH-1:0] chanMode,
   input logic noIndexMode,
   input logic measRun,
   output logic [NUM_CH-1:0][`ENC_CNT_W-1:0] chanCount,
   output logic [NUM_CH-1:0][`ENC_CNT_W-1:0] chanPeriod,
   output logic [NUM_CH-1:0] chanPeriodValid,
   output logic [NUM_CH-1:0] chanDir,
   output logic [2*NUM_CH-1:0] trackState,
   output logic indexState,
   output logic countersActive
);
   localparam int NT = 2 * NUM_CH;

   localparam enc_top_state_t TOP_RST = '{
      gate: ENC_GATE_IDLE,
      runPrev: 1'b0,
      compLevel: '0,
      sync1: '0,
      sync2: '0,
      idxComp: `ENC_INDEX_IDLE,
      idxSync1: `ENC_INDEX_IDLE,
      idxSync2: `ENC_INDEX_IDLE,
      idxPrev: `ENC_INDEX_IDLE,
      timer: '0,
      frac: '0
   };

   enc_top_state_t q;
   enc_top_state_t d;
   logic signed [`ENC_LEVEL_W:0] hiLevel;
   logic signed [`ENC_LEVEL_W:0] loLevel;
   logic signed [`ENC_LEVEL_W-1:0] thrEff;
   logic [`ENC_LEVEL_W-1:0] hystEff;
   logic [`ENC_CNT_W-1:0] fracSum;
   logic runRise;
   logic idxRise;

   // Hysteresis comparator; above hi sets, below lo clears, else holds
   function automatic logic hyst_compare(
      input logic prev,
      input logic signed [`ENC_LEVEL_W-1:0] lvl,
      input logic signed [`ENC_LEVEL_W:0] hi,
      input logic signed [`ENC_LEVEL_W:0] lo
   );
      logic signed [`ENC_LEVEL_W:0] wide;
      wide = {lvl[`ENC_LEVEL_W-1], lvl};
      if (prev) begin
         hyst_compare = !(wide < lo);
      end else begin
         hyst_compare = wide > hi;
      end
   endfunction

   // Fixed levels stand until adjustable thresholds are fitted
   assign thrEff = FIXED_LEVELS ? `ENC_THRESH_MV : thresholdMv;
   assign hystEff = FIXED_LEVELS ? `ENC_HYST_MV : hysteresis_width;
   assign hiLevel = {thrEff[`ENC_LEVEL_W-1], thrEff}
      + $signed({2'b00, hystEff[`ENC_LEVEL_W-1:1]});
   assign loLevel = {thrEff[`ENC_LEVEL_W-1], thrEff}
      - $signed({2'b00, hystEff[`ENC_LEVEL_W-1:1]});

   assign runRise = measRun & ~q.runPrev;
   assign idxRise = q.idxSync2 & ~q.idxPrev;

   always_comb begin
      d = q;
      d.runPrev = measRun;
      for (int t = 0; t < NT; t++) begin
         d.compLevel[t] = hyst_compare(q.compLevel[t], trackLevel[t], hiLevel, loLevel);
      end
      // Index shares the comparator levels of channel one
      d.idxComp = hyst_compare(q.idxComp, indexLevel, hiLevel, loLevel);
      d.sync1 = q.compLevel;
      d.sync2 = q.sync1;
      d.idxSync1 = q.idxComp;
      d.idxSync2 = q.idxSync1;
      d.idxPrev = q.idxSync2;

      // 10.24 timing ticks per cycle: carry the fraction so long
      // periods keep the exact 256 MHz scale
      fracSum = q.frac + `ENC_CNT_W'(`ENC_TICK_REM);
      if (fracSum >= `ENC_CNT_W'(`ENC_SYS_CLK_HZ)) begin
         d.frac = fracSum - `ENC_CNT_W'(`ENC_SYS_CLK_HZ);
         d.timer = q.timer + `ENC_CNT_W'(`ENC_TICK_INT) + `ENC_CNT_W'(1);
      end else begin
         d.frac = fracSum;
         d.timer = q.timer + `ENC_CNT_W'(`ENC_TICK_INT);
      end

      // No trigger input here: gating hangs on start and index alone
      unique case (q.gate)
         ENC_GATE_IDLE: begin
            if (runRise) begin
               // A fresh index edge is required on every run unless noIndexMode is set
               d.gate = noIndexMode ? ENC_GATE_RUN : ENC_GATE_WAIT;
            end
         end
         ENC_GATE_WAIT: begin
            if (!measRun) begin
               d.gate = ENC_GATE_IDLE;
            end else if (noIndexMode || idxRise) begin
               d.gate = ENC_GATE_RUN;
            end
         end
         ENC_GATE_RUN: begin
            if (!measRun) begin
               d.gate = ENC_GATE_IDLE;
            end
         end
         default: d.gate = ENC_GATE_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= TOP_RST;
      end else begin
         q <= d;
      end
   end

   assign countersActive = (q.gate == ENC_GATE_RUN);
   assign trackState = q.sync2;
   assign indexState = q.idxSync2;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_chan
         enc_ch_if chIf ();
         assign chIf.trackFirst = q.sync2[2*c + `ENC_TRACK_FIRST];
         assign chIf.trackSecond = q.sync2[2*c + `ENC_TRACK_SECOND];
         assign chIf.countEn = countersActive;
         assign chIf.clear = runRise;
         assign chIf.mode = chanMode[c];
         assign chIf.timeNow = q.timer;
         assign chanCount[c] = chIf.count;
         assign chanPeriod[c] = chIf.period;
         assign chanPeriodValid[c] = chIf.periodValid;
         assign chanDir[c] = chIf.dir;

         enc_channel u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(chIf.chan)
         );
      end
   endgenerate

   property p_wait_index;
      @(posedge clk) disable iff (sys_rst)
      q.gate == ENC_GATE_WAIT && measRun && !noIndexMode && !idxRise
      |=> q.gate == ENC_GATE_WAIT && !countersActive;
   endproperty
   a_wait_index: assert property (p_wait_index) else $error("counters left wait early");

   property p_index_start;
      @(posedge clk) disable iff (sys_rst)
      q.gate == ENC_GATE_WAIT && measRun && idxRise |=> countersActive;
   endproperty
   a_index_start: assert property (p_index_start) else $error("index edge did not start");

   property p_start_rearm;
      @(posedge clk) disable iff (sys_rst)
      runRise && !noIndexMode |=> q.gate == ENC_GATE_WAIT;
   endproperty
   a_start_rearm: assert property (p_start_rearm) else $error("start did not rearm index");

   property p_no_index;
      @(posedge clk) disable iff (sys_rst)
      runRise && noIndexMode |=> countersActive;
   endproperty
   a_no_index: assert property (p_no_index) else $error("no-index start failed");

   property p_rise_hyst;
      @(posedge clk) disable iff (sys_rst)
      !q.compLevel[0] && $signed({trackLevel[0][`ENC_LEVEL_W-1], trackLevel[0]}) > hiLevel
      |=> q.compLevel[0] ##2 trackState[0];
   endproperty
   a_rise_hyst: assert property (p_rise_hyst) else $error("comparator missed high level");

   property p_hold_band;
      @(posedge clk) disable iff (sys_rst)
      q.compLevel[0] && $signed({trackLevel[0][`ENC_LEVEL_W-1], trackLevel[0]}) >= loLevel
      |=> q.compLevel[0];
   endproperty
   a_hold_band: assert property (p_hold_band) else $error("comparator dropped inside band");

   property p_fixed_edge;
      @(posedge clk) disable iff (sys_rst)
      FIXED_LEVELS && !q.compLevel[0]
      && trackLevel[0] == `ENC_THRESH_MV + (`ENC_HYST_MV >> 1)
      |=> !q.compLevel[0];
   endproperty
   a_fixed_edge: assert property (p_fixed_edge) else $error("switched at the high level");

   property p_sync_lag;
      @(posedge clk) disable iff (sys_rst)
      $rose(q.compLevel[1]) ##1 !$past(sys_rst) |=> trackState[1];
   endproperty
   a_sync_lag: assert property (p_sync_lag) else $error("synchroniser lag wrong");

   property p_timer_step;
      @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> (q.timer - $past(q.timer) == 10) || (q.timer - $past(q.timer) == 11);
   endproperty
   a_timer_step: assert property (p_timer_step) else $error("timer step wrong");

   property p_index_idle;
      @(posedge clk) disable iff (sys_rst)
      q.idxComp && $signed({indexLevel[`ENC_LEVEL_W-1], indexLevel}) >= loLevel
      |=> q.idxComp;
   endproperty
   a_index_idle: assert property (p_index_idle) else $error("idle index fell");

   c_index_run: cover property (@(posedge clk) disable iff (sys_rst)
      q.gate == ENC_GATE_WAIT ##1 q.gate == ENC_GATE_RUN);
   c_noindex_run: cover property (@(posedge clk) disable iff (sys_rst)
      runRise && noIndexMode);
   c_stop: cover property (@(posedge clk) disable iff (sys_rst)
      q.gate == ENC_GATE_RUN ##1 q.gate == ENC_GATE_IDLE);
endmodule // enc_counter

//--- pkg/enc_ch_if.sv
// Link between the counter top and one counting channel
`timescale 1ns/1ps
`include "enc_params.svh"
interface enc_ch_if;
   import enc_pkg::*;
   logic trackFirst;
   logic trackSecond;
   logic countEn;
   logic clear;
   enc_mode_t mode;
   logic [`ENC_CNT_W-1:0] timeNow;
   logic [`ENC_CNT_W-1:0] count;
   logic [`ENC_CNT_W-1:0] period;
   logic periodValid;
   logic dir;

   modport top (
      output trackFirst, trackSecond, countEn, clear, mode, timeNow,
      input count, period, periodValid, dir
   );
   modport chan (
      input trackFirst, trackSecond, countEn, clear, mode, timeNow,
      output count, period, periodValid, dir
   );
endinterface

//--- pkg/enc_params.svh
// Constants of the incremental encoder counter: sizes, levels, timing
`ifndef ENC_PARAMS_SVH
`define ENC_PARAMS_SVH

`define ENC_NUM_CH 4
`define ENC_NUM_TRACKS 8
`define ENC_LEVEL_W 16
`define ENC_CNT_W 32

// Track positions inside a channel pair
`define ENC_TRACK_FIRST 0
`define ENC_TRACK_SECOND 1

// Comparator levels in millivolts
`define ENC_THRESH_MV 16'h05DC
`define ENC_HYST_MV 16'h01F4

// Index comparator idles high while the input floats
`define ENC_INDEX_IDLE 1'b1

// Timing clock and system clock rates, in hertz
`define ENC_SYS_CLK_HZ 25000000
`define ENC_TIMING_CLK_HZ 256000000
// Whole and fractional timing ticks per system clock cycle
`define ENC_TICK_INT (`ENC_TIMING_CLK_HZ / `ENC_SYS_CLK_HZ)
`define ENC_TICK_REM (`ENC_TIMING_CLK_HZ % `ENC_SYS_CLK_HZ)

`endif

//--- pkg/enc_pkg.sv
// Types of the incremental encoder counter
package enc_pkg;
`include "enc_params.svh"

   typedef enum logic [2:0] {
      ENC_MODE_EVENT = 3'h1,
      ENC_MODE_TIME = 3'h2,
      ENC_MODE_QUAD = 3'h4
   } enc_mode_t;

   typedef enum logic [2:0] {
      ENC_GATE_IDLE = 3'h1,
      ENC_GATE_WAIT = 3'h2,
      ENC_GATE_RUN = 3'h4
   } enc_gate_t;

   typedef struct packed {
      logic [`ENC_CNT_W-1:0] count;
      logic [`ENC_CNT_W-1:0] period;
      logic [`ENC_CNT_W-1:0] stamp;
      logic stampValid;
      logic periodValid;
      logic dir;
      logic [1:0] prevTracks;
   } enc_chan_state_t;

   typedef struct packed {
      enc_gate_t gate;
      logic runPrev;
      logic [`ENC_NUM_TRACKS-1:0] compLevel;
      logic [`ENC_NUM_TRACKS-1:0] sync1;
      logic [`ENC_NUM_TRACKS-1:0] sync2;
      logic idxComp;
      logic idxSync1;
      logic idxSync2;
      logic idxPrev;
      logic [`ENC_CNT_W-1:0] timer;
      logic [`ENC_CNT_W-1:0] frac;
   } enc_top_state_t;
endpackage

//--- tb/enc_sensor_model.sv
// Encoder sensor model: converter levels of eight tracks and the index
`timescale 1ns/1ps
`include "enc_params.svh"
module enc_sensor_model
   import enc_pkg::*;
(
   input logic clk,
   output logic signed [`ENC_NUM_TRACKS-1:0][`ENC_LEVEL_W-1:0] trackLevel,
   output logic signed [`ENC_LEVEL_W-1:0] indexLevel
);
   logic [`ENC_NUM_TRACKS-1:0] bitsQ;

   // Random swing past the switching points, never parked inside the band
   function automatic logic signed [`ENC_LEVEL_W-1:0] swing(input logic b);
      return b ? 16'(16'h06D7 + $urandom_range(0, 3000)) : 16'(16'h04E1 - $urandom_range(0, 3000));
   endfunction

   initial begin
      bitsQ = '0;
      for (int i = 0; i < `ENC_NUM_TRACKS; i++) begin
         trackLevel[i] = -16'sh01F4;
      end
      // Open index input floats high
      indexLevel = 16'sh0BB8;
   end

   task automatic setTracks(input int ch, input logic first, input logic second);
      @(posedge clk);
      // Bookkeeping only; blocking so a following step reads the new phase
      bitsQ[2*ch] = first;
      bitsQ[2*ch+1] = second;
      trackLevel[2*ch] <= swing(first);
      trackLevel[2*ch+1] <= swing(second);
   endtask

   task automatic setLevel(input int trk, input logic signed [`ENC_LEVEL_W-1:0] mv);
      @(posedge clk);
      trackLevel[trk] <= mv;
   endtask

   task automatic setIndex(input logic signed [`ENC_LEVEL_W-1:0] mv);
      @(posedge clk);
      indexLevel <= mv;
   endtask

   // Gray step: one track moves, second lags first by a quarter period going forward
   task automatic quadStep(input int ch, input logic fwd);
      logic a;
      logic b;
      a = bitsQ[2*ch];
      b = bitsQ[2*ch+1];
      if (fwd == (a == b)) begin
         a = ~a;
      end else begin
         b = ~b;
      end
      setTracks(ch, a, b);
   endtask
endmodule // enc_sensor_model

//--- tb/incremental_encoder_counter_tb.sv
// Self-checking bench of the four-channel encoder counter
`timescale 1ns/1ps
`include "enc_params.svh"
module incremental_encoder_counter_tb;
   import enc_pkg::*;
   typedef struct {int sel; logic [31:0] val;} enc_tb_exp_t;
   localparam int selCnt = 0;
   localparam int selPer = 4;
   localparam int selDir = 8;
   localparam int selAct = 12;
   localparam int selIdx = 13;
   localparam int selTrk = 14;
   localparam int selPv = 15;
   logic clk;
   logic sys_rst;
   logic signed [`ENC_NUM_TRACKS-1:0][`ENC_LEVEL_W-1:0] trackLevel;
   logic signed [`ENC_LEVEL_W-1:0] indexLevel;
   logic signed [`ENC_LEVEL_W-1:0] thresholdMv;
   logic [`ENC_LEVEL_W-1:0] hysteresisWidth;
   enc_mode_t [`ENC_NUM_CH-1:0] chanMode;
   logic noIndexMode;
   logic measRun;
   logic [`ENC_NUM_CH-1:0][`ENC_CNT_W-1:0] chanCount;
   logic [`ENC_NUM_CH-1:0][`ENC_CNT_W-1:0] chanPeriod;
   logic [`ENC_NUM_CH-1:0] chanPeriodValid;
   logic [`ENC_NUM_CH-1:0] chanDir;
   logic [`ENC_NUM_TRACKS-1:0] trackState;
   logic indexState;
   logic countersActive;
   int fails = 0;
   int checksDone = 0;
   int quadPhase = 0;
   int quadExp = 0;
   enc_tb_exp_t expQ[$];
   logic signed [15:0] bandMv[4] = '{16'sh06D6, 16'sh06D7, 16'sh04E2, 16'sh04E1};
   logic bandExp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   enc_sensor_model u_sensor (.clk(clk), .trackLevel(trackLevel), .indexLevel(indexLevel));

   enc_counter u_dut (
      .clk(clk), .sys_rst(sys_rst), .trackLevel(trackLevel), .indexLevel(indexLevel),
      .thresholdMv(thresholdMv), .hysteresis_width(hysteresisWidth), .chanMode(chanMode),
      .noIndexMode(noIndexMode), .measRun(measRun), .chanCount(chanCount),
      .chanPeriod(chanPeriod), .chanPeriodValid(chanPeriodValid), .chanDir(chanDir),
      .trackState(trackState), .indexState(indexState), .countersActive(countersActive)
   );

   function automatic logic [31:0] actual(input int sel);
      case (sel)
         selAct: return {31'h0, countersActive};
         selIdx: return {31'h0, indexState};
         selTrk: return {24'h0, trackState};
         selPv: return {28'h0, chanPeriodValid};
         default: ;
      endcase
      if (sel < selPer) return chanCount[sel];
      if (sel < selDir) return chanPeriod[sel-selPer];
      return {31'h0, chanDir[sel-selDir]};
   endfunction

   task automatic expectVal(input int sel, input logic [31:0] val);
      expQ.push_back('{sel, val});
   endtask

   task automatic settle();
      repeat (8) @(posedge clk);
   endtask

   task automatic pulses(input int ch, input int n);
      repeat (n) begin
         u_sensor.setTracks(ch, 1'b1, 1'($urandom_range(0, 1)));
         u_sensor.setTracks(ch, 1'b0, 1'($urandom_range(0, 1)));
      end
   endtask

   // Expected quadrature count: only first-track flips count
   task automatic quad(input int n, input logic fwd);
      repeat (n) begin
         if (fwd ? (quadPhase % 2 == 0) : (quadPhase % 2 == 1)) quadExp += fwd ? 1 : -1;
         quadPhase = (quadPhase + (fwd ? 1 : 3)) % 4;
         u_sensor.quadStep(2, fwd);
      end
   endtask

   task automatic indexPulse();
      u_sensor.setIndex(-16'sh03E8);
      repeat (3) @(posedge clk);
      u_sensor.setIndex(16'sh0BB8);
   endtask

   task automatic tallyAndFinish();
      $display("Checks %0d, mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      enc_tb_exp_t e;
      forever begin
         @(negedge clk);
         while (expQ.size() > 0) begin
            e = expQ.pop_front();
            checksDone++;
            if (actual(e.sel) !== e.val) begin
               fails++;
               $display("MISMATCH t=%0t sel=%0d got=%h exp=%h", $time, e.sel, actual(e.sel), e.val);
            end
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tallyAndFinish();
   end

   initial begin
      int n;
      int fwdN;
      void'($urandom(32'hFAE8EA2B));
      sys_rst = 1'b1;
      measRun = 1'b0;
      noIndexMode = 1'b0;
      thresholdMv = `ENC_THRESH_MV;
      hysteresisWidth = `ENC_HYST_MV;
      chanMode[0] = ENC_MODE_EVENT;
      chanMode[1] = ENC_MODE_TIME;
      chanMode[2] = ENC_MODE_QUAD;
      chanMode[3] = ENC_MODE_QUAD;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      settle();
      expectVal(selAct, 32'h0);
      expectVal(selIdx, 32'h1);
      // Band edges on track 0 and index; the index rise here precedes the start
      foreach (bandMv[i]) begin
         u_sensor.setLevel(0, bandMv[i]);
         u_sensor.setIndex(bandMv[(i+2)%4]);
         settle();
         expectVal(selTrk, {31'h0, bandExp[i]});
         expectVal(selIdx, {31'h0, bandExp[(i+2)%4]});
      end
      @(posedge clk);
      measRun <= 1'b1;
      settle();
      pulses(0, 3);
      settle();
      expectVal(selAct, 32'h0);
      expectVal(selCnt, 32'h0);
      indexPulse();
      settle();
      expectVal(selAct, 32'h1);
      n = $urandom_range(2, 20);
      pulses(0, n);
      u_sensor.setTracks(1, 1'b1, 1'b0);
      u_sensor.setTracks(1, 1'b0, 1'b1);
      repeat (23) @(posedge clk);
      u_sensor.setTracks(1, 1'b1, 1'b1);
      fwdN = $urandom_range(4, 30);
      quad(fwdN, 1'b1);
      settle();
      expectVal(selCnt+2, 32'(quadExp));
      expectVal(selDir+2, 32'h1);
      quad(fwdN + $urandom_range(1, 20), 1'b0);
      u_sensor.setTracks(3, 1'b1, 1'b1);
      u_sensor.setTracks(3, 1'b0, 1'b0);
      u_sensor.quadStep(3, 1'b1);
      u_sensor.quadStep(3, 1'b1);
      settle();
      expectVal(selCnt+2, 32'(quadExp));
      expectVal(selDir+2, 32'h0);
      expectVal(selCnt+3, 32'h1);
      expectVal(selCnt, 32'(n));
      expectVal(selDir, 32'h0);
      expectVal(selCnt+1, 32'h2);
      expectVal(selPer+1, 32'h100);
      @(posedge clk);
      measRun <= 1'b0;
      settle();
      @(posedge clk);
      measRun <= 1'b1;
      settle();
      pulses(0, 2);
      settle();
      expectVal(selAct, 32'h0);
      expectVal(selCnt+2, 32'h0);
      expectVal(selPv, 32'h0);
      expectVal(selCnt, 32'h0);
      @(posedge clk);
      measRun <= 1'b0;
      noIndexMode <= 1'b1;
      settle();
      @(posedge clk);
      measRun <= 1'b1;
      settle();
      pulses(0, 3);
      settle();
      expectVal(selAct, 32'h1);
      expectVal(selCnt, 32'h3);
      @(posedge clk);
      sys_rst <= 1'b1;
      settle();
      expectVal(selCnt, 32'h0);
      expectVal(selAct, 32'h0);
      repeat (2) @(negedge clk);
      tallyAndFinish();
   end
endmodule // incremental_encoder_counter_tb
